// ==== hdl/timer_regs.svh ====
// register map, field positions and reset values of the dual 8-bit timer
// assumes a 32-bit apb slave with one register per aligned word
// Operation
// R1: timer a counts while its stop bit is 0, holds while it is 1, and the stop bit resets to 0.
// R2: with the pin as source, edge select 0 counts rising edges and 1 falling edges; resets to 0.
// R3: timer a prescaler input is the system clock over two at source 0 and the pin at source 1.
// R4: timer a prescale codes 0 to 7 divide by 1 to 128 in powers of two; top bit set divides by 256.
// R5: timer b count is readable and writable by software and resets to zero.
// R6: timer b has a readable and writable 8-bit reload register that resets to zero.
// R7: timer b counts while its stop bit is 0, holds while it is 1, and the stop bit resets to 0.
// R8: timer b counts the system clock over two through the same power-of-two prescaler.
// R9: timer b overflow sets its pending flag; writing a byte with only that bit at zero clears it.
// R10: timer a overflow sets its pending flag; writing a byte with only that bit at zero clears it.
// R11: timer b increments per tick and reloads from the reload register when it overflows.
// R12: the count pin is synchronised to the system clock and its selected edge detected first.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register indices; byte address is four times the index
`define IDX_FLAG    6'h0c
`define IDX_A_CTRL  6'h11
`define IDX_B_COUNT 6'h12
`define IDX_B_RLD   6'h13
`define IDX_B_CTRL  6'h14
`define IDX_A_COUNT 6'h15

// control field positions
`define BIT_STOP    6
`define BIT_EDGE    5
`define BIT_SRC     4

// flag register field positions
`define BIT_FLAG_B  5
`define BIT_FLAG_A  4

// reset values and the maximum count
`define RST_CTRL    8'h00
`define RST_COUNT   8'h00
`define RST_RELOAD  8'h00
`define COUNT_MAX   8'hff

`endif

// ==== hdl/timer_pkg.sv ====
// shared types of the dual 8-bit timer
// assumes nothing beyond the register header
package timer_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [3:0] psc_code_t;
	typedef logic [8:0] divisor_t;
endpackage

// ==== hdl/prescaler.sv ====
// power-of-two prescaler: passes one of every 2^n input ticks
// assumes tick_in is a one-cycle pulse on clk_sys, already gated by stop
`timescale 1ns/1ps
`include "timer_regs.svh"
module prescaler (
	input  wire logic               clk_sys,
	input  wire logic               srst,
	input  wire logic               tick_in,
	input  wire timer_pkg::psc_code_t code,
	output logic                    tick_out
);
	logic [7:0] div_cnt;
	logic [7:0] mask;

	// codes with the top bit set all divide by 256
	always_comb begin
		mask = code[3] ? 8'hff : 8'((9'h001 << code[2:0]) - 9'h001); // R4
	end

	assign tick_out = tick_in && ((div_cnt & mask) == mask); // R4

	// free-running; a code change may give one short period
	always_ff @(posedge clk_sys) begin
		if (srst)
			div_cnt <= 8'h00;
		else if (tick_in)
			div_cnt <= div_cnt + 8'h01;
	end

	// helper: input ticks since the last output tick
	logic [8:0] gap;
	logic       gap_valid;
	timer_pkg::divisor_t div_exp;
	assign div_exp = code[3] ? 9'h100 : 9'(9'h001 << code[2:0]);

	always_ff @(posedge clk_sys) begin
		if (srst || code != $past(code)) begin
			gap       <= 9'h000;
			gap_valid <= 1'b0;
		end else if (tick_out) begin
			gap       <= 9'h000;
			gap_valid <= 1'b1;
		end else if (tick_in) begin
			gap <= gap + 9'h001;
		end
	end

	property p_period;
		@(posedge clk_sys) disable iff (srst)
		tick_out && gap_valid && $stable(code) |-> gap == 9'(div_exp - 9'h001);
	endproperty
	a_period: assert property (p_period) else $error("prescaler period wrong"); // R4
endmodule

// ==== hdl/edge_sync.sv ====
// count pin synchroniser and selectable edge detector
// assumes pin_in is asynchronous to clk_sys
`timescale 1ns/1ps
module edge_sync (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic pin_in,
	input  wire logic edge_sel,
	output logic      edge_pulse
);
	logic meta;
	logic sync;
	logic prev;

	// two flops before any logic looks at the pin
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin_in; // R12
			sync <= meta;
			prev <= sync;
		end
	end

	// 0 picks rising, 1 picks falling
	assign edge_pulse = edge_sel ? (prev && !sync) : (sync && !prev); // R2 R12

	sequence s_rise;
		(!edge_sel && $rose(pin_in)) ##1 (!edge_sel && pin_in)[*2];
	endsequence
	sequence s_fall;
		(edge_sel && $fell(pin_in)) ##1 (edge_sel && !pin_in)[*2];
	endsequence
	property p_rise;
		@(posedge clk_sys) disable iff (srst) s_rise |-> edge_pulse;
	endproperty
	property p_fall;
		@(posedge clk_sys) disable iff (srst) s_fall |-> edge_pulse;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed"); // R2
	a_fall: assert property (p_fall) else $error("falling edge missed"); // R12
endmodule

// ==== hdl/dual_eight_bit_timer.sv ====
// two 8-bit timers with prescalers and overflow pending flags, on an apb slave
// assumes apb signals are synchronous to clk_sys; the count pin is asynchronous
`timescale 1ns/1ps
`include "timer_regs.svh"
module dual_eight_bit_timer (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_a_count_input,
	output logic             timer_a_pending_flag,
	output logic             timer_b_pending_flag
);

	// control fields of timer a
	logic                 timer_a_stop;
	logic                 timer_a_edge_select;
	logic                 timer_a_clock_source;
	timer_pkg::psc_code_t timer_a_prescale;

	// control fields and registers of timer b, and the timer a count
	logic                 timer_b_stop;
	timer_pkg::psc_code_t timer_b_prescale;
	timer_pkg::reg8_t     timer_b_count;
	timer_pkg::reg8_t     timer_b_reload;
	timer_pkg::reg8_t     timer_a_count;

	// bus decode
	logic                 setup_phase;
	logic                 access_phase;
	logic                 word_ok;
	logic                 sel_flag;
	logic                 sel_a_ctrl;
	logic                 sel_b_count;
	logic                 sel_b_rld;
	logic                 sel_b_ctrl;
	logic                 sel_a_count;
	logic                 mapped;
	logic                 wr_any;
	logic                 wr_flag;
	logic                 wr_a_ctrl;
	logic                 wr_b_count;
	logic                 wr_b_rld;
	logic                 wr_b_ctrl;
	timer_pkg::reg8_t     next_rdata;

	// tick chain
	logic                 half_phase;
	logic                 half_tick;
	logic                 ext_edge;
	logic                 a_tick_in;
	logic                 a_tick;
	logic                 b_tick_in;
	logic                 b_tick;
	logic                 a_overflow;
	logic                 b_overflow;

	// apb phases; the slave never inserts wait states
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign pready       = 1'b1;

	// address decode; unaligned or unknown words answer with pslverr
	always_comb begin
		word_ok     = (paddr[1:0] == 2'b00);
		sel_flag    = word_ok && (paddr[7:2] == `IDX_FLAG);
		sel_a_ctrl  = word_ok && (paddr[7:2] == `IDX_A_CTRL);
		sel_b_count = word_ok && (paddr[7:2] == `IDX_B_COUNT);
		sel_b_rld   = word_ok && (paddr[7:2] == `IDX_B_RLD);
		sel_b_ctrl  = word_ok && (paddr[7:2] == `IDX_B_CTRL);
		sel_a_count = word_ok && (paddr[7:2] == `IDX_A_COUNT);
		mapped      = sel_flag || sel_a_ctrl || sel_b_count || sel_b_rld
		              || sel_b_ctrl || sel_a_count;
	end

	assign pslverr = access_phase && !mapped;

	// only byte lane 0 carries register data
	assign wr_any     = access_phase && pwrite && pstrb[0];
	assign wr_flag    = wr_any && sel_flag;
	assign wr_a_ctrl  = wr_any && sel_a_ctrl;
	assign wr_b_count = wr_any && sel_b_count;
	assign wr_b_rld   = wr_any && sel_b_rld;
	assign wr_b_ctrl  = wr_any && sel_b_ctrl;

	// read mux; bits not held read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (sel_flag) begin
			next_rdata[`BIT_FLAG_B] = timer_b_pending_flag;
			next_rdata[`BIT_FLAG_A] = timer_a_pending_flag;
		end
		if (sel_a_ctrl) begin
			next_rdata[`BIT_STOP] = timer_a_stop;
			next_rdata[`BIT_EDGE] = timer_a_edge_select;
			next_rdata[`BIT_SRC]  = timer_a_clock_source;
			next_rdata[3:0]       = timer_a_prescale;
		end
		if (sel_b_count)
			next_rdata = timer_b_count;
		if (sel_b_rld)
			next_rdata = timer_b_reload;
		if (sel_b_ctrl) begin
			next_rdata[`BIT_STOP] = timer_b_stop;
			next_rdata[3:0]       = timer_b_prescale;
		end
		if (sel_a_count)
			next_rdata = timer_a_count;
	end

	// read data is captured in the setup phase so it comes from a flop;
	// counts therefore show their value one cycle before the access edge
	always_ff @(posedge clk_sys) begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (setup_phase && !pwrite)
			prdata <= {24'h00_0000, next_rdata};
	end

	// timer a control, all fields reset to zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_a_stop         <= 1'b0; // R1
			timer_a_edge_select  <= 1'b0; // R2
			timer_a_clock_source <= 1'b0;
			timer_a_prescale     <= 4'h0;
		end else if (wr_a_ctrl) begin
			timer_a_stop         <= pwdata[`BIT_STOP];
			timer_a_edge_select  <= pwdata[`BIT_EDGE];
			timer_a_clock_source <= pwdata[`BIT_SRC];
			timer_a_prescale     <= pwdata[3:0];
		end
	end

	// timer b control
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_b_stop     <= 1'b0; // R7
			timer_b_prescale <= 4'h0;
		end else if (wr_b_ctrl) begin
			timer_b_stop     <= pwdata[`BIT_STOP];
			timer_b_prescale <= pwdata[3:0];
		end
	end

	// timer b reload value
	always_ff @(posedge clk_sys) begin
		if (srst)
			timer_b_reload <= `RST_RELOAD; // R6
		else if (wr_b_rld)
			timer_b_reload <= pwdata[7:0]; // R6
	end

	// system clock over two: one enable every other cycle, shared by both timers
	always_ff @(posedge clk_sys) begin
		if (srst)
			half_phase <= 1'b0;
		else
			half_phase <= !half_phase;
	end
	assign half_tick = half_phase;

	// pin synchroniser and edge select
	edge_sync u_edge (
		.clk_sys    (clk_sys),
		.srst       (srst),
		.pin_in     (timer_a_count_input),
		.edge_sel   (timer_a_edge_select),
		.edge_pulse (ext_edge)
	);

	// stop gates the source ahead of the prescaler so both hold
	assign a_tick_in = !timer_a_stop && (timer_a_clock_source ? ext_edge : half_tick); // R1 R3
	assign b_tick_in = !timer_b_stop && half_tick; // R7 R8

	prescaler u_psc_a (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.tick_in  (a_tick_in),
		.code     (timer_a_prescale),
		.tick_out (a_tick)
	);

	prescaler u_psc_b (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.tick_in  (b_tick_in),
		.code     (timer_b_prescale),
		.tick_out (b_tick)
	);

	// timer a wraps from max to zero
	assign a_overflow = a_tick && (timer_a_count == `COUNT_MAX);

	always_ff @(posedge clk_sys) begin
		if (srst)
			timer_a_count <= `RST_COUNT;
		else if (a_tick)
			timer_a_count <= timer_a_count + 8'h01; // R1
	end

	// a software write wins over a tick and suppresses that overflow
	assign b_overflow = b_tick && (timer_b_count == `COUNT_MAX) && !wr_b_count;

	always_ff @(posedge clk_sys) begin
		if (srst)
			timer_b_count <= `RST_COUNT; // R5
		else if (wr_b_count)
			timer_b_count <= pwdata[7:0]; // R5
		else if (b_overflow)
			timer_b_count <= timer_b_reload; // R11
		else if (b_tick)
			timer_b_count <= timer_b_count + 8'h01; // R11
	end

	// pending flags: a write clears each bit written as zero; a new overflow wins
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_a_pending_flag <= 1'b0;
			timer_b_pending_flag <= 1'b0;
		end else begin
			timer_a_pending_flag <= a_overflow // R10
				|| (timer_a_pending_flag && !(wr_flag && !pwdata[`BIT_FLAG_A]));
			timer_b_pending_flag <= b_overflow // R9
				|| (timer_b_pending_flag && !(wr_flag && !pwdata[`BIT_FLAG_B]));
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// timer a held while stopped
	property p_a_stop;
		timer_a_stop |=> $stable(timer_a_count);
	endproperty
	a_a_stop: assert property (p_a_stop) else $error("timer a moved while stopped"); // R1

	// timer a from fsys/2 at divide 1 advances once per two cycles
	sequence s_a_sys_run;
		(!timer_a_stop && !timer_a_clock_source && timer_a_prescale == 4'h0)[*3];
	endsequence
	property p_a_sys;
		s_a_sys_run |-> timer_a_count == 8'($past(timer_a_count, 2) + 8'h01);
	endproperty
	a_a_sys: assert property (p_a_sys) else $error("timer a fsys/2 rate wrong"); // R3

	// timer a on the pin source moves only on a selected edge
	property p_a_ext;
		timer_a_clock_source && !ext_edge |=> $stable(timer_a_count);
	endproperty
	a_a_ext: assert property (p_a_ext) else $error("timer a moved without pin edge"); // R3

	// software write of timer b count lands on the next edge
	property p_b_write;
		wr_b_count |=> timer_b_count == $past(pwdata[7:0]);
	endproperty
	a_b_write: assert property (p_b_write) else $error("timer b count write lost"); // R5

	// reload register write
	property p_b_reload;
		wr_b_rld |=> timer_b_reload == $past(pwdata[7:0]) ##1 timer_b_reload == $past(pwdata[7:0], 2);
	endproperty
	a_b_reload: assert property (p_b_reload) else $error("reload write lost"); // R6

	// timer b held while stopped
	property p_b_stop;
		timer_b_stop && !wr_b_count |=> $stable(timer_b_count);
	endproperty
	a_b_stop: assert property (p_b_stop) else $error("timer b moved while stopped"); // R7

	// timer b at divide 1 advances once per two cycles away from overflow
	sequence s_b_run;
		(!timer_b_stop && timer_b_prescale == 4'h0 && !wr_b_count
		 && timer_b_count < 8'hfe)[*3];
	endsequence
	property p_b_rate;
		s_b_run |-> timer_b_count == 8'($past(timer_b_count, 2) + 8'h01);
	endproperty
	a_b_rate: assert property (p_b_rate) else $error("timer b fsys/2 rate wrong"); // R8

	// overflow reloads the count and raises the flag together
	property p_b_ovf;
		b_overflow |=> timer_b_count == $past(timer_b_reload) && timer_b_pending_flag;
	endproperty
	a_b_ovf: assert property (p_b_ovf) else $error("timer b overflow handling wrong"); // R11

	// flag b clear by writing its bit as zero
	property p_b_clear;
		wr_flag && !pwdata[`BIT_FLAG_B] && !b_overflow |=> !timer_b_pending_flag;
	endproperty
	a_b_clear: assert property (p_b_clear) else $error("flag b not cleared"); // R9

	// flag a set by overflow, even during a clearing write
	property p_a_set;
		a_overflow |=> timer_a_pending_flag && timer_a_count == 8'h00;
	endproperty
	a_a_set: assert property (p_a_set) else $error("flag a not set on overflow"); // R10

	// flag a survives a write that leaves its bit at one
	property p_a_keep;
		timer_a_pending_flag && wr_flag && pwdata[`BIT_FLAG_A] |=> timer_a_pending_flag;
	endproperty
	a_a_keep: assert property (p_a_keep) else $error("flag a cleared wrongly"); // R10

	// flag a clear by writing its bit as zero, unless an overflow lands
	property p_a_clear;
		wr_flag && !pwdata[`BIT_FLAG_A] && !a_overflow |=> !timer_a_pending_flag;
	endproperty
	a_a_clear: assert property (p_a_clear) else $error("flag a not cleared"); // R10

	// flag b rises only on an overflow, never from a write
	property p_b_set_only;
		!timer_b_pending_flag && !b_overflow |=> !timer_b_pending_flag;
	endproperty
	a_b_set_only: assert property (p_b_set_only) else $error("flag b set spuriously"); // R9

	// a detected pin edge at divide 1 moves timer a by one
	property p_a_edge;
		timer_a_clock_source && !timer_a_stop && timer_a_prescale == 4'h0 && ext_edge
		|=> timer_a_count == 8'($past(timer_a_count) + 8'h01);
	endproperty
	a_a_edge: assert property (p_a_edge) else $error("pin edge not counted"); // R12

	// a read of the reload register returns the stored value
	property p_rd_reload;
		access_phase && !pwrite && sel_b_rld |-> prdata == {24'h00_0000, timer_b_reload};
	endproperty
	a_rd_reload: assert property (p_rd_reload) else $error("reload read wrong"); // R6

	// timer a count is read-only: a write alone never moves it
	property p_a_ro;
		wr_any && sel_a_count && !a_tick |=> $stable(timer_a_count);
	endproperty
	a_a_ro: assert property (p_a_ro) else $error("timer a count written"); // R1

	// the fsys/2 enable never stands two cycles in a row
	property p_half;
		half_tick |=> !half_tick;
	endproperty
	a_half: assert property (p_half) else $error("fsys/2 enable too fast"); // R8

endmodule

// ==== tb/count_pin_model.sv ====
// far-side model of the external count pin
// assumes the bench pulses go for one cycle on clk_sys; pin idles at its last level
`timescale 1ns/1ps
module count_pin_model (
	input  wire logic       clk_sys,
	input  wire logic       go,
	input  wire logic [8:0] toggles,
	output logic            pin,
	output logic            busy
);
	logic [8:0] left = 9'h000;
	logic [1:0] gap  = 2'h0;

	initial pin = 1'b0;

	// each level is held three cycles, so the two-flop sync always sees it;
	// a plain always block, since the pin also takes a start value above
	always @(posedge clk_sys) begin
		if (go) begin
			left <= toggles;
			gap  <= 2'h0;
		end else if (left != 9'h000) begin
			if (gap == 2'h2) begin
				pin  <= ~pin;
				left <= left - 9'h001;
				gap  <= 2'h0;
			end else begin
				gap <= gap + 2'h1;
			end
		end
	end

	assign busy = go | (left != 9'h000);
endmodule

// ==== tb/dual_eight_bit_timer_tb.sv ====
// self-checking bench for the dual 8-bit timer, apb master tasks
// assumes pready answers without wait states; loops are still bounded
`timescale 1ns/1ps
module dual_eight_bit_timer_tb;
	logic        clk_sys, srst, psel, penable, pwrite, pin_go;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0]  pstrb;
	logic        pready, pslverr, rerr, pin, pin_busy, flag_a, flag_b;
	logic [8:0]  pin_toggles;
	int          fails, num_checks;

	dual_eight_bit_timer i_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_a_count_input(pin), .timer_a_pending_flag(flag_a),
		.timer_b_pending_flag(flag_b));

	count_pin_model i_pin (.clk_sys(clk_sys), .go(pin_go), .toggles(pin_toggles),
		.pin(pin), .busy(pin_busy));

	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; the request is held until pready is seen high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			conclude();
		end
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	task automatic rd(logic [7:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask

	// count advance between two reads whose setup edges lie k cycles apart
	task automatic measure(string what, logic [7:0] cnt, logic [7:0] ctl, logic [7:0] cv,
			int k, logic [7:0] exp);
		logic [7:0] v0;
		logic [7:0] dv;
		wr(ctl, cv);
		rd(cnt);
		v0 = rdata[7:0];
		repeat (k - 3) @(posedge clk_sys);
		rd(cnt);
		dv = rdata[7:0] - v0;
		check(what, {24'h000000, exp}, {24'h000000, dv});
	endtask

	// timer a advance over a burst of pin toggles
	task automatic pin_delta(logic [7:0] cv, logic [8:0] t, logic [7:0] exp);
		logic [7:0] v0;
		logic [7:0] dv;
		int         n;
		wr(8'h44, cv);
		rd(8'h54);
		v0 = rdata[7:0];
		pin_toggles <= t;
		pin_go      <= 1'b1;
		@(posedge clk_sys);
		pin_go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pin_busy !== 1'b0 && n < 100);
		if (n >= 100) begin
			fails++;
			conclude();
		end
		repeat (6) @(posedge clk_sys);
		rd(8'h54);
		dv = rdata[7:0] - v0;
		check("timer a pin count", {24'h000000, exp}, {24'h000000, dv});
	endtask

	task automatic t_reset();
		check("a flag after reset", 32'h0, {31'h0, flag_a});
		check("b flag after reset", 32'h0, {31'h0, flag_b});
		rd(8'h48);
		check("b count after reset", 32'h0, rdata);
		rd(8'h30);
		check("flag reg reset", 32'h0, rdata);
		rd(8'h44);
		check("a control reset", 32'h0, rdata);
		rd(8'h4c);
		check("b reload reset", 32'h0, rdata);
		rd(8'h50);
		check("b control reset", 32'h0, rdata);
		rd(8'h00);
		check("unmapped error", 32'h1, {31'h0, rerr});
		check("unmapped data", 32'h0, rdata);
		rd(8'h49);
		check("unaligned error", 32'h1, {31'h0, rerr});
		$display("test reset done");
	endtask

	task automatic t_b_regs();
		wr(8'h50, 8'h40);
		wr(8'h48, 8'h5a);
		wr(8'h4c, 8'ha5);
		rd(8'h48);
		check("b count rw", 32'h5a, rdata);
		rd(8'h4c);
		check("b reload rw", 32'ha5, rdata);
		repeat (40) @(posedge clk_sys);
		rd(8'h48);
		check("b count held", 32'h5a, rdata);
		pstrb <= 4'h0;
		wr(8'h48, 8'h33);
		pstrb <= 4'h1;
		rd(8'h48);
		check("b count strobe off", 32'h5a, rdata);
		wr(8'h4c, 8'h00);
		for (int c = 0; c < 10; c++) begin
			measure("b rate", 8'h48, 8'h50, (c == 9) ? 8'h0f : 8'(c),
				8 << ((c > 7) ? 8 : c), 8'h04);
		end
		measure("b stopped", 8'h48, 8'h50, 8'h40, 64, 8'h00);
		$display("test timer b rate done");
	endtask

	task automatic t_b_reload();
		wr(8'h44, 8'h40);
		wr(8'h4c, 8'h80);
		wr(8'h48, 8'hfe);
		wr(8'h50, 8'h00);
		repeat (10) @(posedge clk_sys);
		wr(8'h50, 8'h40);
		rd(8'h48);
		check("b reloaded", 32'h1, 32'(rdata >= 32'h80 && rdata <= 32'h85));
		check("b flag set", 32'h1, {31'h0, flag_b});
		rd(8'h30);
		check("b flag read", 32'h20, rdata & 32'h20);
		wr(8'h30, 8'hff);
		@(posedge clk_sys);
		check("b flag kept", 32'h1, {31'h0, flag_b});
		wr(8'h30, 8'hdf);
		@(posedge clk_sys);
		check("b flag cleared", 32'h0, {31'h0, flag_b});
		$display("test timer b reload done");
	endtask

	task automatic t_a();
		int n;
		pin_delta(8'h10, 9'd5, 8'h03);
		pin_delta(8'h30, 9'd5, 8'h03);
		pin_delta(8'h50, 9'd4, 8'h00);
		pin_delta(8'h11, 9'd8, 8'h02);
		measure("a system rate", 8'h54, 8'h44, 8'h00, 64, 8'h20);
		measure("a top code", 8'h54, 8'h44, 8'h09, 2048, 8'h04);
		wr(8'h44, 8'h40);
		wr(8'h30, 8'hef);
		@(posedge clk_sys);
		check("a flag cleared stopped", 32'h0, {31'h0, flag_a});
		wr(8'h44, 8'h00);
		n = 0;
		while (flag_a !== 1'b1 && n < 700) begin
			@(posedge clk_sys);
			n++;
		end
		check("a flag set", 32'h1, {31'h0, flag_a});
		rd(8'h30);
		check("a flag read", 32'h10, rdata & 32'h10);
		wr(8'h30, 8'hef);
		@(posedge clk_sys);
		check("a flag cleared", 32'h0, {31'h0, flag_a});
		$display("test timer a done");
	endtask

	// reset, then the scenarios in order
	initial begin
		fails       = 0;
		num_checks  = 0;
		srst        = 1'b1;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h00000000;
		pstrb       = 4'h1;
		pin_go      = 1'b0;
		pin_toggles = 9'h000;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_b_regs();
		t_b_reload();
		t_a();
		conclude();
	end
endmodule
